// ===== common/nfc_cfg.svh
// Overview of operation
// - An unsigned code c of width b converts to the float c/(2^b-1), from zero to one.
// - A signed code c of width b converts to max(c/(2^(b-1)-1), -1.0), from -1 to 1.
// - The most negative signed code is clamped to -1.0, so -127 and -128 (b=8) both give -1.
// - Float to unsigned code clamps to [0,1], scales by 2^b-1 and rounds to nearest.
// - Float to signed code clamps to [-1,1], scales by 2^(b-1)-1 and rounds to nearest.
// - Signed codes are b-bit two's complement and unsigned codes plain b-bit binary.
// - The formulas use width b even when the code container is wider.
// - Width b is the component's bit count in its store and is given with each request.
// - One signed conversion serves every caller, whatever the source of the value.
// - A division by zero gives an arbitrary value but never stalls or hangs the datapath.
// - Float results are rounded to nearest, within half a unit of the 24-bit mantissa, over the range [-1,1].
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH

`define NFC_MAX_W_DEF   16
`define NFC_QGUARD      26
`define NFC_F_ZERO      32'h0000_0000
`define NFC_F_NEG_ONE   32'hbf80_0000
`define NFC_EXP_BIAS    127
`define NFC_EXP_ALLONE  8'hff
`define NFC_FRAC_W      24
`define NFC_MANT_W      23
`define NFC_EXP_W       8

`endif

// ===== common/nfc_pkg.sv
package nfc_pkg;

    // conversion direction of one request
    typedef enum logic {
        NFC_FIX_TO_FLT,
        NFC_FLT_TO_FIX
    } nfc_dir_t;

    // control sequence of the converter
    typedef enum logic [1:0] {
        NFC_IDLE,
        NFC_DIV,
        NFC_DONE
    } nfc_state_t;

endpackage

// ===== rtl/nfc_divider.sv
`timescale 1ns/1ps
`include "nfc_cfg.svh"

// restoring divider, one quotient bit per cycle
module nfc_divider #(
    parameter int NW = 58,
    parameter int DW = 16
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          start,
    input  wire logic [NW-1:0] num,
    input  wire logic [DW-1:0] den,
    output logic               done,
    output logic [NW-1:0]      quot,
    output logic               rem_nz
);
    localparam int CW = $clog2(NW + 1);

    logic [NW-1:0] shf_q;
    logic [DW:0]   rem_q;
    logic [DW-1:0] den_q;
    logic [CW-1:0] cnt_q;
    logic          run_q;
    logic [DW:0]   trial;

    // shift in the next numerator bit; a zero divisor simply yields all ones
    assign trial = {rem_q[DW-1:0], shf_q[NW-1]};

    // the count is fixed, so a zero divisor cannot hold the loop open
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            run_q <= 1'b0;
            cnt_q <= '0;
        end else if (start) begin
            run_q <= 1'b1;
            cnt_q <= CW'(NW);
        end else if (run_q) begin
            cnt_q <= cnt_q - 1'b1;
            run_q <= (cnt_q != CW'(1));
        end
    end

    // datapath: quotient bits enter at the bottom of the shift register
    always_ff @(posedge mclk) begin
        if (start) begin
            shf_q <= num;
            rem_q <= '0;
            den_q <= den;
        end else if (run_q) begin
            if (trial >= {1'b0, den_q}) begin
                rem_q <= trial - {1'b0, den_q};
                shf_q <= {shf_q[NW-2:0], 1'b1};
            end else begin
                rem_q <= trial;
                shf_q <= {shf_q[NW-2:0], 1'b0};
            end
        end
    end

    // finish pulse registered on the same edge as the last step
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            done <= 1'b0;
        end else begin
            done <= run_q && (cnt_q == CW'(1));
        end
    end

    assign quot   = shf_q;
    assign rem_nz = (rem_q != '0);

endmodule

// ===== rtl/nfc_converter.sv
`timescale 1ns/1ps
`include "nfc_cfg.svh"

// normalized fixed-point <-> single-precision float converter
module nfc_converter #(
    parameter int MAX_W = `NFC_MAX_W_DEF,
    localparam int BW   = $clog2(MAX_W + 1)
) (
    input  wire logic          mclk,
    input  wire logic          reset_n,
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic          in_dir,
    input  wire logic          in_signed,
    input  wire logic [BW-1:0] in_bits,
    input  wire logic [31:0]   in_data,
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [31:0]        out_data
);
    localparam int QB = MAX_W + `NFC_QGUARD;
    localparam int NW = MAX_W + QB;
    localparam int FW = `NFC_FRAC_W;
    localparam int MW = `NFC_MANT_W;
    localparam int PW = FW + 1 + MAX_W;

    nfc_pkg::nfc_state_t state_q;
    logic [31:0]         out_q;
    logic                neg_q;

    // scale factor 2^b-1 or 2^(b-1)-1; b=0 unsigned (or b=1 signed) gives a zero divisor
    function automatic logic [MAX_W-1:0] scale_of(input logic [BW-1:0] b, input logic sgn);
        logic [MAX_W:0] one;
        logic [MAX_W:0] s;
        one = (MAX_W+1)'(1);
        if (sgn) begin
            s = (one << (b - 1'b1)) - one;
        end else begin
            s = (one << b) - one;
        end
        return s[MAX_W-1:0];
    endfunction

    // position of the leading one of the quotient
    function automatic int lead_pos(input logic [QB:0] q);
        int p;
        p = 0;
        for (int i = 0; i <= QB; i++) begin
            if (q[i]) begin
                p = i;
            end
        end
        return p;
    endfunction

    // ---------------- request decode ----------------
    logic [BW-1:0]    bits;
    logic [MAX_W-1:0] scale;
    logic [MAX_W-1:0] cod_shl;
    logic [MAX_W-1:0] cod_sx;
    logic [MAX_W-1:0] cod_mag;
    logic             cod_neg;
    logic             cod_min;

    // widths above the container are clamped to it
    assign bits  = (in_bits > BW'(MAX_W)) ? BW'(MAX_W) : in_bits;
    assign scale = scale_of(bits, in_signed);

    // only the low b bits carry the code, whatever the container width
    always_comb begin
        cod_shl = in_data[MAX_W-1:0] << (BW'(MAX_W) - bits);
        if (in_signed) begin
            cod_sx = MAX_W'($signed(cod_shl) >>> (BW'(MAX_W) - bits));
        end else begin
            cod_sx = cod_shl >> (BW'(MAX_W) - bits);
        end
        cod_neg = in_signed && cod_sx[MAX_W-1];
        cod_mag = cod_neg ? MAX_W'(-cod_sx) : cod_sx;
        // magnitude past the scale is the one code outside the range
        cod_min = cod_neg && (cod_mag > scale);
    end

    // ---------------- float to fixed (single cycle) ----------------
    logic          f_sgn;
    logic [7:0]    f_exp;
    logic [MW-1:0] f_frac;
    logic          f_nan;
    logic [FW:0]   f_fix;
    logic [PW-1:0] f_prod;
    logic [PW-1:0] f_rnd;
    logic [MAX_W-1:0] f_mag;
    logic [MAX_W-1:0] f_code;
    logic [31:0]   f_out;

    assign f_sgn  = in_data[31];
    assign f_exp  = in_data[30:MW];
    assign f_frac = in_data[MW-1:0];
    assign f_nan  = (f_exp == `NFC_EXP_ALLONE) && (f_frac != '0);

    // clamp into [0,1] or [-1,1] as a 1.24 magnitude; NaN maps to zero
    always_comb begin
        if (f_nan) begin
            f_fix = '0;
        end else if (f_sgn && !in_signed) begin
            f_fix = '0;
        end else if (f_exp >= 8'(`NFC_EXP_BIAS)) begin
            f_fix = (FW+1)'(1) << FW;
        end else if ((8'(`NFC_EXP_BIAS - 1) - f_exp) > 8'(FW) || f_exp == '0) begin
            f_fix = '0; // denormals lie far below half a code step
        end else begin
            f_fix = {1'b0, 1'b1, f_frac} >> (8'(`NFC_EXP_BIAS - 1) - f_exp);
        end
    end

    // scale, then add half an lsb and truncate: round to nearest, ties away
    always_comb begin
        f_prod = PW'(f_fix) * PW'(scale);
        f_rnd  = (f_prod + (PW'(1) << (FW - 1))) >> FW;
        f_mag  = f_rnd[MAX_W-1:0];
        f_code = (f_sgn && in_signed) ? MAX_W'(-f_mag) : f_mag;
        if (in_signed) begin
            f_out = 32'($signed(f_code));
        end else begin
            f_out = 32'(f_code);
        end
    end

    // ---------------- fixed to float (divider) ----------------
    logic          div_start;
    logic          div_done;
    logic [NW-1:0] div_quot;
    logic          div_rnz;

    assign div_start = (state_q == nfc_pkg::NFC_IDLE) && in_valid
                     && (in_dir == nfc_pkg::NFC_FIX_TO_FLT)
                     && !cod_min && (cod_mag != '0);

    // enough quotient bits past the smallest ratio for a rounded 24-bit mantissa
    nfc_divider #(
        .NW (NW),
        .DW (MAX_W)
    ) u_div (
        .mclk    (mclk),
        .reset_n (reset_n),
        .start   (div_start),
        .num     ({cod_mag, QB'(0)}),
        .den     (scale),
        .done    (div_done),
        .quot    (div_quot),
        .rem_nz  (div_rnz)
    );

    // normalize quotient q*2^-QB into sign, exponent and mantissa
    logic [QB:0]   q;
    logic [QB:0]   qn;
    int            qp;
    logic [7:0]    n_exp;
    logic          n_grd;
    logic          n_stk;
    logic [30:0]   n_mag;
    logic [31:0]   n_out;

    always_comb begin
        q     = div_quot[QB:0];
        qp    = lead_pos(q);
        qn    = q << (QB - qp);
        n_exp = 8'(`NFC_EXP_BIAS + qp - QB);
        n_grd = qn[QB-MW-1];
        n_stk = (qn[QB-MW-2:0] != '0) || div_rnz;
        // a mantissa carry on rounding steps the exponent, as intended
        n_mag = {n_exp, qn[QB-1 -: MW]}
              + 31'(n_grd && (n_stk || qn[QB-MW]));
        n_out = {neg_q, n_mag};
    end

    // ---------------- control ----------------
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            state_q <= nfc_pkg::NFC_IDLE;
        end else begin
            unique case (state_q)
                nfc_pkg::NFC_IDLE: begin
                    if (in_valid) begin
                        state_q <= div_start ? nfc_pkg::NFC_DIV : nfc_pkg::NFC_DONE;
                    end
                end
                nfc_pkg::NFC_DIV: begin
                    if (div_done) begin
                        state_q <= nfc_pkg::NFC_DONE;
                    end
                end
                nfc_pkg::NFC_DONE: begin
                    if (out_ready) begin
                        state_q <= nfc_pkg::NFC_IDLE;
                    end
                end
            endcase
        end
    end

    // sign of the code travels alongside the division
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            neg_q <= 1'b0;
        end else if (div_start) begin
            neg_q <= cod_neg;
        end
    end

    // result register: immediate results in idle, quotients when the divider ends
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            out_q <= `NFC_F_ZERO;
        end else if (state_q == nfc_pkg::NFC_IDLE && in_valid) begin
            if (in_dir == nfc_pkg::NFC_FLT_TO_FIX) begin
                out_q <= f_out;
            end else if (cod_min) begin
                out_q <= `NFC_F_NEG_ONE;
            end else if (cod_mag == '0) begin
                out_q <= `NFC_F_ZERO; // zero is exact in both encodings
            end
        end else if (state_q == nfc_pkg::NFC_DIV && div_done) begin
            out_q <= n_out;
        end
    end

    assign in_ready  = (state_q == nfc_pkg::NFC_IDLE);
    assign out_valid = (state_q == nfc_pkg::NFC_DONE);
    assign out_data  = out_q;

endmodule

// ===== tb/nfc_converter_chk.sv
`timescale 1ns/1ps
module nfc_converter_chk #(
    parameter int MAX_W = 16,
    localparam int BW   = $clog2(MAX_W + 1)
) (
    input wire logic          mclk,
    input wire logic          reset_n,
    input wire logic          in_valid,
    input wire logic          in_ready,
    input wire logic          in_dir,
    input wire logic          in_signed,
    input wire logic [BW-1:0] in_bits,
    input wire logic [31:0]   in_data,
    input wire logic          out_valid,
    input wire logic          out_ready,
    input wire logic [31:0]   out_data
);
    // request accepted at this edge
    wire take = in_valid && in_ready;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    chk_take_busy: assert property (take |=> !in_ready)
        else $error("converter still ready after a take");
    chk_f2x_lat: assert property (take && in_dir |=> out_valid)
        else $error("float to code result late");
    chk_x2f_lat: assert property (take && !in_dir && !in_signed && in_bits != 0 &&
        in_data[0] |=> !out_valid [*8] ##52 out_valid)
        else $error("code to float result not on time");
    chk_out_hold: assert property (out_valid && !out_ready |=>
        out_valid && $stable(out_data))
        else $error("result dropped before consumed");
    chk_out_free: assert property (out_valid && out_ready |=> !out_valid && in_ready)
        else $error("converter not idle after handshake");
    chk_one_side: assert property (!(in_ready && out_valid))
        else $error("ready while a result is pending");
    chk_neg_clamp: assert property (take && !in_dir && in_signed && in_bits == 8 &&
        in_data[7:0] == 8'h80 |=> out_valid && out_data == 32'hbf800000)
        else $error("most negative code not clamped");
    chk_zero_code: assert property (take && !in_dir && in_data[15:0] == 0 |=>
        out_valid && out_data == 32'h0)
        else $error("zero code not converted to zero");
    chk_nan_code: assert property (take && in_dir && in_data[30:23] == 8'hff &&
        in_data[22:0] != 0 |=> out_valid && out_data == 32'h0)
        else $error("nan input gave a nonzero code");

    cov_f2x: cover property (take && in_dir);
    cov_x2f: cover property (take && !in_dir);
    cov_stall: cover property (out_valid && !out_ready);
endmodule

bind nfc_converter nfc_converter_chk #(.MAX_W(MAX_W)) i_nfc_converter_chk (
    .mclk(mclk), .reset_n(reset_n), .in_valid(in_valid), .in_ready(in_ready),
    .in_dir(in_dir), .in_signed(in_signed), .in_bits(in_bits), .in_data(in_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data));

// ===== tb/nfc_sink.sv
`timescale 1ns/1ps
// float side consumer: takes results, or stalls when asked
module nfc_sink (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        stall,
    input  wire logic        out_valid,
    input  wire logic [31:0] out_data,
    output logic             out_ready,
    output logic [31:0]      got,
    output logic [15:0]      got_cnt
);
    // ready lags stall by one cycle, as a slow stage would
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            out_ready <= 1'b0;
        end else begin
            out_ready <= !stall;
        end
    end

    // capture each consumed word
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            got_cnt <= 16'h0;
            got     <= 32'h0;
        end else if (out_valid && out_ready) begin
            got_cnt <= got_cnt + 16'h1;
            got     <= out_data;
        end
    end
endmodule

// ===== tb/normalized_fixed_point_converter_tb_top.sv
`timescale 1ns/1ps
module normalized_fixed_point_converter_tb_top;
    logic mclk, reset_n, in_valid, in_ready, in_dir, in_signed, out_valid, out_ready, stall;
    logic [4:0]  in_bits;
    logic [31:0] in_data, out_data, got;
    logic [15:0] got_cnt;
    int          err_total, checked, cycles;

    nfc_converter #(.MAX_W(16)) i_nfc_converter (.mclk(mclk), .reset_n(reset_n),
        .in_valid(in_valid), .in_ready(in_ready), .in_dir(in_dir), .in_signed(in_signed),
        .in_bits(in_bits), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data));
    nfc_sink i_nfc_sink (.mclk(mclk), .reset_n(reset_n), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .got(got), .got_cnt(got_cnt));

    // free running clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic close_out();
        if (err_total == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one request; in_ready is settled at the negedge before the taking edge
    task automatic conv(input logic d, input logic s, input logic [4:0] b,
                        input logic [31:0] din, output logic [31:0] r);
        logic [15:0] n;
        n = got_cnt;
        @(posedge mclk);
        in_valid <= 1'b1;
        in_dir <= d;
        in_signed <= s;
        in_bits <= b;
        in_data <= din;
        @(negedge mclk);
        while (in_ready !== 1'b1) @(negedge mclk);
        @(posedge mclk);
        in_valid <= 1'b0;
        for (int i = 0; i < 200 && got_cnt == n; i++) @(posedge mclk);
        // a result that never arrives is a mismatch, not a silent stale value
        if (got_cnt == n) begin
            err_total++;
            $display("[FAIL] result_handshake expected within 200 cycles seen none");
        end
        r = got;
    endtask

    task automatic cc(input string nm, input logic d, input logic s, input logic [4:0] b,
                      input logic [31:0] din, input logic [31:0] e);
        logic [31:0] v;
        conv(d, s, b, din, v);
        chk(nm, e, v);
    endtask

    task automatic t_unorm_in();
        cc("u8_max", 0, 0, 5'h08, 32'h000000ff, 32'h3f800000);
        cc("u8_wide", 0, 0, 5'h08, 32'h000001ff, 32'h3f800000);
        cc("u16_max", 0, 0, 5'h10, 32'h0000ffff, 32'h3f800000);
        cc("u2_third", 0, 0, 5'h02, 32'h00000001, 32'h3eaaaaab);
        cc("u8_zero", 0, 0, 5'h08, 32'h00000000, 32'h00000000);
    endtask

    task automatic t_snorm_in();
        cc("s8_max", 0, 1, 5'h08, 32'h0000007f, 32'h3f800000);
        cc("s8_m127", 0, 1, 5'h08, 32'h00000081, 32'hbf800000);
        cc("s8_m128", 0, 1, 5'h08, 32'h00000080, 32'hbf800000);
        cc("s16_min", 0, 1, 5'h10, 32'h00008000, 32'hbf800000);
        cc("s8_zero", 0, 1, 5'h08, 32'h00000000, 32'h00000000);
    endtask

    task automatic t_unorm_out();
        cc("fu_one", 1, 0, 5'h08, 32'h3f800000, 32'h000000ff);
        cc("fu_two", 1, 0, 5'h08, 32'h40000000, 32'h000000ff);
        cc("fu_neg", 1, 0, 5'h08, 32'hbf800000, 32'h00000000);
        cc("fu_half", 1, 0, 5'h08, 32'h3f000000, 32'h00000080);
        cc("fu_16", 1, 0, 5'h10, 32'h3f800000, 32'h0000ffff);
        cc("fu_nan", 1, 0, 5'h08, 32'h7fc00000, 32'h00000000);
        cc("fu_inf", 1, 0, 5'h08, 32'h7f800000, 32'h000000ff);
    endtask

    task automatic t_snorm_out();
        cc("fs_one", 1, 1, 5'h08, 32'h3f800000, 32'h0000007f);
        cc("fs_mone", 1, 1, 5'h08, 32'hbf800000, 32'hffffff81);
        cc("fs_mtwo", 1, 1, 5'h08, 32'hc0000000, 32'hffffff81);
        cc("fs_half", 1, 1, 5'h08, 32'h3f000000, 32'h00000040);
        cc("fs_mhalf", 1, 1, 5'h08, 32'hbf000000, 32'hffffffc0);
    endtask

    // result must stand while the float side stalls
    task automatic t_stall();
        stall <= 1'b1;
        fork
            begin
                repeat (20) @(posedge mclk);
                chk("held_valid", 32'h1, {31'h0, out_valid});
                chk("held_data", 32'h0000007f, out_data);
                stall <= 1'b0;
            end
        join_none
        cc("stall_res", 1, 1, 5'h08, 32'h3f800000, 32'h0000007f);
    endtask

    // reset in the middle of a division: idle, empty result, then a clean request
    task automatic t_reset();
        @(posedge mclk);
        in_valid <= 1'b1;
        in_dir <= 1'b0;
        in_signed <= 1'b0;
        in_bits <= 5'h08;
        in_data <= 32'h00000001;
        @(posedge mclk);
        in_valid <= 1'b0;
        repeat (10) @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk("rst_ready", 32'h1, {31'h0, in_ready});
        chk("rst_valid", 32'h0, {31'h0, out_valid});
        chk("rst_data", 32'h0, out_data);
        cc("rst_after", 1, 0, 5'h08, 32'h3f000000, 32'h00000080);
    endtask

    task automatic t_div_zero();
        logic [31:0] v;
        logic [15:0] n;
        n = got_cnt;
        conv(1'b0, 1'b1, 5'h01, 32'h00000001, v);
        conv(1'b0, 1'b0, 5'h00, 32'h00000001, v);
        chk("dz_count", 32'h2, {16'h0, got_cnt - n});
    endtask

    // reset for 8 cycles, then every scenario in turn
    initial begin
        reset_n = 1'b0;
        in_valid = 1'b0;
        in_dir = 1'b0;
        in_signed = 1'b0;
        in_bits = 5'h00;
        in_data = 32'h0;
        stall = 1'b0;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        t_unorm_in();
        t_snorm_in();
        t_unorm_out();
        t_snorm_out();
        t_stall();
        t_reset();
        t_div_zero();
        close_out();
    end
endmodule
